/* File: pkg/sffs_pkg.sv */
package sffs_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int          SFFS_ADDR_W       = 8;
   localparam int          SFFS_DATA_W       = 16;
   localparam int          SFFS_NUM_FAULTS   = 5;
   localparam logic [7:0]  SFFS_SUPPLY_OFS   = 8'h0E;
   localparam logic [15:0] SFFS_RESET_VALUE  = 16'h0000;

   // ----------------------------------------------------------------
   // field positions: status bit of fault i, its ack bit sits one below
   // ----------------------------------------------------------------
   localparam int SFFS_CRC_FLAG_POS      = 15;
   localparam int SFFS_SYNC_FLAG_POS     = 13;
   localparam int SFFS_PUMP_FLAG_POS     = 11;
   localparam int SFFS_ABSENT_FLAG_POS   = 9;
   localparam int SFFS_OVERCUR_FLAG_POS  = 7;
   localparam int SFFS_ACK_OFFSET        = 1;
   localparam int SFFS_PAIR_STRIDE       = 2;

   // fault indices, in status bit order, lowest bit first
   typedef enum logic [2:0] {
      SFFS_F_OVERCUR,
      SFFS_F_ABSENT,
      SFFS_F_PUMP,
      SFFS_F_SYNC,
      SFFS_F_CRC
   } sffs_fault_t;

   // status bit position of fault index i
   function automatic int sffs_flag_pos(input int i);
      return SFFS_OVERCUR_FLAG_POS + SFFS_PAIR_STRIDE * i;
   endfunction

endpackage

/* File: rtl/sffs_supply_fault_status.sv */
`timescale 1ns/1ps

// Summary of operation
// - bit 15 reads 1 after a CRC error, 0 when none occurred.
// - writing 1 to bits 15 and 14 together clears CRC flag and pin share.
// - bit 13 is set when the boost sync input goes missing.
// - writing 1 to bits 13 and 12 together clears sync-loss flag and pin share.
// - bit 11 is set on a charge pump fault, else reads 0.
// - writing 1 to bits 11 and 10 together clears pump fault and pin share.
// - bit 9 is set when the charge pump capacitor is missing.
// - writing 1 to bits 9 and 8 together clears missing-pump flag and pin share.
// - bit 7 reads 1 after an input over-current fault.
// - writing 1 to bits 7 and 6 together clears over-current flag and pin share.
// - register lives at offset 0Eh and resets to all zeros.
module sffs_supply_fault_status
   import sffs_pkg::*;
#(
   parameter int NUM_FAULTS = SFFS_NUM_FAULTS
) (
   input  wire logic                   MCLK,
   input  wire logic                   ARST_N,
   input  wire logic                   CLK_EN,
   input  wire logic                   REG_WR,
   input  wire logic [SFFS_ADDR_W-1:0] REG_ADDR,
   input  wire logic [SFFS_DATA_W-1:0] REG_WDATA,
   output logic      [SFFS_DATA_W-1:0] REG_RDATA,
   input  wire logic                   CRC_FAULT_EVT,
   input  wire logic                   SYNC_LOSS_EVT,
   input  wire logic                   PUMP_FAULT_EVT,
   input  wire logic                   PUMP_ABSENT_EVT,
   input  wire logic                   INPUT_OVERCURRENT_EVT,
   output logic                        FAULT_IRQ
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic                   addr_hit;
   logic                   wr_hit;

   // crc error
   logic                   crc_fault_set;
   logic                   crc_fault_ack;
   logic                   crc_fault_flag_reg;
   logic                   crc_fault_flag_next;

   // missing boost sync
   logic                   sync_loss_set;
   logic                   sync_loss_ack;
   logic                   sync_loss_flag_reg;
   logic                   sync_loss_flag_next;

   // charge pump fault
   logic                   pump_fault_set;
   logic                   pump_fault_ack;
   logic                   pump_fault_flag_reg;
   logic                   pump_fault_flag_next;

   // missing charge pump part
   logic                   pump_absent_set;
   logic                   pump_absent_ack;
   logic                   pump_absent_flag_reg;
   logic                   pump_absent_flag_next;

   // input over-current
   logic                   input_overcurrent_set;
   logic                   input_overcurrent_ack;
   logic                   input_overcurrent_flag_reg;
   logic                   input_overcurrent_flag_next;

   logic [NUM_FAULTS-1:0]  flags_next;
   logic [SFFS_DATA_W-1:0] rdata_next;
   logic                   irq_next;

   // ----------------------------------------------------------------
   // ack positions
   // ----------------------------------------------------------------
   localparam int CRC_ACK_POS     = SFFS_CRC_FLAG_POS - SFFS_ACK_OFFSET;
   localparam int SYNC_ACK_POS    = SFFS_SYNC_FLAG_POS - SFFS_ACK_OFFSET;
   localparam int PUMP_ACK_POS    = SFFS_PUMP_FLAG_POS - SFFS_ACK_OFFSET;
   localparam int ABSENT_ACK_POS  = SFFS_ABSENT_FLAG_POS - SFFS_ACK_OFFSET;
   localparam int OVERCUR_ACK_POS = SFFS_OVERCUR_FLAG_POS - SFFS_ACK_OFFSET;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // a clear needs a one on the status bit and on its ack bit at once
   function automatic logic pair_hit(
      input logic [SFFS_DATA_W-1:0] wdata,
      input int                     flag_pos,
      input int                     ack_pos
   );
      return wdata[flag_pos] && wdata[ack_pos];
   endfunction

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   // reads and writes share the one address compare
   assign addr_hit = (REG_ADDR == SFFS_SUPPLY_OFS);
   assign wr_hit   = REG_WR && addr_hit;

   // ----------------------------------------------------------------
   // crc error: status 15, ack 14
   // ----------------------------------------------------------------
   // detectors run on MCLK, so no synchroniser is needed
   assign crc_fault_set = CRC_FAULT_EVT;
   assign crc_fault_ack = wr_hit && pair_hit(REG_WDATA,
                                             SFFS_CRC_FLAG_POS,
                                             CRC_ACK_POS);

   // set is checked last: an event in the clearing cycle wins
   always_comb begin
      crc_fault_flag_next = crc_fault_flag_reg;

      if (crc_fault_ack) begin
         crc_fault_flag_next = 1'b0;
      end

      if (crc_fault_set) begin
         crc_fault_flag_next = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         crc_fault_flag_reg <= SFFS_RESET_VALUE[SFFS_CRC_FLAG_POS];
      end else if (CLK_EN) begin
         crc_fault_flag_reg <= crc_fault_flag_next;
      end
   end

   // ----------------------------------------------------------------
   // missing boost sync: status 13, ack 12
   // ----------------------------------------------------------------
   // flag holds while the sync monitor keeps reporting loss
   assign sync_loss_set = SYNC_LOSS_EVT;
   assign sync_loss_ack = wr_hit && pair_hit(REG_WDATA,
                                             SFFS_SYNC_FLAG_POS,
                                             SYNC_ACK_POS);

   // a lone status or ack bit leaves the flag alone
   always_comb begin
      sync_loss_flag_next = sync_loss_flag_reg;

      if (sync_loss_ack) begin
         sync_loss_flag_next = 1'b0;
      end

      if (sync_loss_set) begin
         sync_loss_flag_next = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync_loss_flag_reg <= SFFS_RESET_VALUE[SFFS_SYNC_FLAG_POS];
      end else if (CLK_EN) begin
         sync_loss_flag_reg <= sync_loss_flag_next;
      end
   end

   // ----------------------------------------------------------------
   // charge pump fault: status 11, ack 10
   // ----------------------------------------------------------------
   // a level fault keeps the flag set through each clear, since set wins
   assign pump_fault_set = PUMP_FAULT_EVT;
   assign pump_fault_ack = wr_hit && pair_hit(REG_WDATA,
                                              SFFS_PUMP_FLAG_POS,
                                              PUMP_ACK_POS);

   // same priority as the other flags
   always_comb begin
      pump_fault_flag_next = pump_fault_flag_reg;

      if (pump_fault_ack) begin
         pump_fault_flag_next = 1'b0;
      end

      if (pump_fault_set) begin
         pump_fault_flag_next = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pump_fault_flag_reg <= SFFS_RESET_VALUE[SFFS_PUMP_FLAG_POS];
      end else if (CLK_EN) begin
         pump_fault_flag_reg <= pump_fault_flag_next;
      end
   end

   // ----------------------------------------------------------------
   // missing charge pump part: status 9, ack 8
   // ----------------------------------------------------------------
   // detection runs outside this block; only the flag lives here
   assign pump_absent_set = PUMP_ABSENT_EVT;
   assign pump_absent_ack = wr_hit && pair_hit(REG_WDATA,
                                               SFFS_ABSENT_FLAG_POS,
                                               ABSENT_ACK_POS);

   // same priority as the other flags
   always_comb begin
      pump_absent_flag_next = pump_absent_flag_reg;

      if (pump_absent_ack) begin
         pump_absent_flag_next = 1'b0;
      end

      if (pump_absent_set) begin
         pump_absent_flag_next = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pump_absent_flag_reg <= SFFS_RESET_VALUE[SFFS_ABSENT_FLAG_POS];
      end else if (CLK_EN) begin
         pump_absent_flag_reg <= pump_absent_flag_next;
      end
   end

   // ----------------------------------------------------------------
   // input over-current: status 7, ack 6
   // ----------------------------------------------------------------
   // lowest flag of this half; bits below it are not built here
   assign input_overcurrent_set = INPUT_OVERCURRENT_EVT;
   assign input_overcurrent_ack = wr_hit && pair_hit(REG_WDATA,
                                                     SFFS_OVERCUR_FLAG_POS,
                                                     OVERCUR_ACK_POS);

   // same priority as the other flags
   always_comb begin
      input_overcurrent_flag_next = input_overcurrent_flag_reg;

      if (input_overcurrent_ack) begin
         input_overcurrent_flag_next = 1'b0;
      end

      if (input_overcurrent_set) begin
         input_overcurrent_flag_next = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         input_overcurrent_flag_reg <= SFFS_RESET_VALUE[SFFS_OVERCUR_FLAG_POS];
      end else if (CLK_EN) begin
         input_overcurrent_flag_reg <= input_overcurrent_flag_next;
      end
   end

   // ----------------------------------------------------------------
   // flag vector
   // ----------------------------------------------------------------
   // next values, so a read or the pin never lags the flags by a cycle
   assign flags_next[SFFS_F_CRC]     = crc_fault_flag_next;
   assign flags_next[SFFS_F_SYNC]    = sync_loss_flag_next;
   assign flags_next[SFFS_F_PUMP]    = pump_fault_flag_next;
   assign flags_next[SFFS_F_ABSENT]  = pump_absent_flag_next;
   assign flags_next[SFFS_F_OVERCUR] = input_overcurrent_flag_next;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // ack bits and the unbuilt low faults read back as zero
   always_comb begin
      rdata_next = SFFS_RESET_VALUE;
      if (addr_hit) begin
         rdata_next[SFFS_CRC_FLAG_POS]     = crc_fault_flag_next;
         rdata_next[SFFS_SYNC_FLAG_POS]    = sync_loss_flag_next;
         rdata_next[SFFS_PUMP_FLAG_POS]    = pump_fault_flag_next;
         rdata_next[SFFS_ABSENT_FLAG_POS]  = pump_absent_flag_next;
         rdata_next[SFFS_OVERCUR_FLAG_POS] = input_overcurrent_flag_next;
      end
   end

   // registered so the host always sees a settled word
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         REG_RDATA <= SFFS_RESET_VALUE;
      end else if (CLK_EN) begin
         REG_RDATA <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // interrupt pin
   // ----------------------------------------------------------------
   // pin follows the flags, so it drops with the last paired clear
   assign irq_next = |flags_next;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         FAULT_IRQ <= 1'b0;
      end else if (CLK_EN) begin
         FAULT_IRQ <= irq_next;
      end
   end

endmodule // sffs_supply_fault_status

/* File: sim/sffs_chk_sva.sv */
`timescale 1ns/1ps
module sffs_chk (
   input wire logic MCLK, ARST_N, CLK_EN, REG_WR, CRC_FAULT_EVT, SYNC_LOSS_EVT,
   input wire logic PUMP_FAULT_EVT, PUMP_ABSENT_EVT, INPUT_OVERCURRENT_EVT, FAULT_IRQ,
   input wire logic [7:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA, REG_RDATA
);
   wire logic [15:0] ev = {CRC_FAULT_EVT, 1'b0, SYNC_LOSS_EVT, 1'b0, PUMP_FAULT_EVT, 1'b0,
                           PUMP_ABSENT_EVT, 1'b0, INPUT_OVERCURRENT_EVT, 7'h00};
   wire logic at = CLK_EN && REG_ADDR == 8'h0E;
   // a full status+ack pair anywhere in the write
   wire logic pr = REG_WR && |(REG_WDATA & (REG_WDATA << 1) & 16'hAA80);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   sequence s_keep; at && !pr; endsequence
   sequence s_clr; at && REG_WR && REG_WDATA == 16'hFFC0 && ev == 16'h0000; endsequence
   property p_set; at |=> (REG_RDATA & $past(ev)) == $past(ev); endproperty
   property p_irq; CLK_EN && ev != 16'h0000 |=> FAULT_IRQ; endproperty
   property p_clr; s_clr |=> REG_RDATA == 16'h0000 && !FAULT_IRQ; endproperty
   property p_zero; CLK_EN |=> (REG_RDATA & 16'h557F) == 16'h0000; endproperty
   property p_unmap; CLK_EN && REG_ADDR != 8'h0E |=> REG_RDATA == 16'h0000; endproperty
   property p_keep; s_keep ##1 s_keep |=> (REG_RDATA & $past(REG_RDATA)) == $past(REG_RDATA); endproperty
   property p_or; at |=> FAULT_IRQ == (REG_RDATA != 16'h0000); endproperty
   property p_rst; $rose(ARST_N) |-> REG_RDATA == 16'h0000 && !FAULT_IRQ; endproperty
   property p_hold; !CLK_EN |=> $stable(REG_RDATA) && $stable(FAULT_IRQ); endproperty
   a_hold: assert property (p_hold) else $error("state moved while disabled");
   a_set: assert property (p_set) else $error("flag not set");
   a_irq: assert property (p_irq) else $error("irq not raised");
   a_clr: assert property (p_clr) else $error("clear failed");
   a_zero: assert property (p_zero) else $error("ack bit read 1");
   a_unmap: assert property (p_unmap) else $error("unmapped data");
   a_keep: assert property (p_keep) else $error("flag lost");
   a_or: assert property (p_or) else $error("irq mismatch");
   a_rst: assert property (p_rst) else $error("reset value");
endmodule // sffs_chk

/* File: sim/sffs_host.sv */
`timescale 1ns/1ps
module sffs_host (
   input wire logic MCLK,
   output logic wr,
   output logic [7:0] addr,
   output logic [15:0] wdata
);
   initial begin
      wr = 1'b0;
      addr = 8'h0E;
      wdata = 16'h0000;
   end
   // one-cycle strobe; clears pair status with ack in one access
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(negedge MCLK);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(negedge MCLK);
      wr <= 1'b0;
      addr <= 8'h0E;
   endtask
endmodule // sffs_host

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
   typedef struct {logic [4:0] e; logic [15:0] w, x;} sffs_row_t;
   logic MCLK = 0, ARST_N = 0, cen = 1, irq;
   logic [4:0] ev = 5'h00;
   logic wr;
   logic [7:0] addr;
   logic [15:0] wd, rdata;
   int mismatches, n_compared;
   sffs_row_t rows[10] = '{'{5'h10,16'h0000,16'h8000}, '{5'h1F,16'h0000,16'hAA80},
      '{5'h00,16'h8000,16'hAA80}, '{5'h00,16'h4000,16'hAA80}, '{5'h00,16'hC000,16'h2A80},
      '{5'h00,16'h3000,16'h0A80}, '{5'h00,16'h0C00,16'h0280}, '{5'h00,16'h0300,16'h0080},
      '{5'h00,16'h00C0,16'h0000}, '{5'h01,16'hFFC0,16'h0000}};
   initial forever #2 MCLK = ~MCLK;
   sffs_host i_host (.MCLK(MCLK), .wr(wr), .addr(addr), .wdata(wd));
   sffs_supply_fault_status i_dut (.MCLK(MCLK), .ARST_N(ARST_N), .CLK_EN(cen), .REG_WR(wr),
      .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdata), .CRC_FAULT_EVT(ev[4]),
      .SYNC_LOSS_EVT(ev[3]), .PUMP_FAULT_EVT(ev[2]), .PUMP_ABSENT_EVT(ev[1]),
      .INPUT_OVERCURRENT_EVT(ev[0]), .FAULT_IRQ(irq));
   task chk(input string n, input logic [15:0] s, e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #40000 mismatches++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(negedge MCLK);
      chk("reset", rdata, 16'h0000);
      ARST_N = 1;
      foreach (rows[i]) begin
         @(negedge MCLK) ev = rows[i].e;
         @(negedge MCLK) ev = 5'h00;
         if (rows[i].w != 16'h0000) i_host.wr_reg(8'h0E, rows[i].w);
         chk("flags", rdata, rows[i].x);
         chk("irq", {15'h0000, irq}, {15'h0000, rows[i].x != 16'h0000});
      end
      @(negedge MCLK) ev = 5'h10;
      @(negedge MCLK) ev = 5'h00;
      i_host.wr_reg(8'h0F, 16'hC000);
      chk("unmapped", rdata, 16'h0000);
      @(negedge MCLK) chk("kept", rdata, 16'h8000);
      fork
         i_host.wr_reg(8'h0E, 16'h00C0);
         begin
            @(negedge MCLK) ev = 5'h01;
            @(negedge MCLK) ev = 5'h00;
         end
      join
      chk("setwins", rdata, 16'h8080);
      chk("irqhold", {15'h0000, irq}, 16'h0001);
      i_host.wr_reg(8'h0E, 16'hC0C0);
      chk("clr2", rdata, 16'h0000);
      chk("irqlow", {15'h0000, irq}, 16'h0000);
      @(negedge MCLK) begin
         cen = 0;
         ev = 5'h08;
      end
      @(negedge MCLK) ev = 5'h00;
      chk("frozen", rdata, 16'h0000);
      cen = 1;
      @(negedge MCLK) chk("nolatch", rdata, 16'h0000);
      @(negedge MCLK) ev = 5'h02;
      @(negedge MCLK) ev = 5'h00;
      chk("absent", rdata, 16'h0200);
      ARST_N = 0;
      #1 chk("rerst", rdata, 16'h0000);
      @(negedge MCLK) ARST_N = 1;
      @(negedge MCLK) chk("postrst", {15'h0000, irq}, 16'h0000);
      ev = 5'h10;
      @(negedge MCLK) ev = 5'h00;
      chk("post", rdata, 16'h8000);
      tally_and_finish;
   end
endmodule // tb
bind sffs_supply_fault_status sffs_chk i_chk (.*);
